// ### pps_cfg.svh
// Constants for the positioning program sequencer
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_AW         6
`define PPS_DEPTH      64
`define PPS_W          32
`define PPS_OPC_HI     31
`define PPS_OPC_LO     27
`define PPS_IND_BIT    26
`define PPS_IMM_HI     25
`define PPS_RIDX_HI    2
`define PPS_NREG       8
`define PPS_NRET       4
`define PPS_TRAVEL_MAX 32'sh000F_423F
`define PPS_SPEED_MAX  32'sh0000_2710
`define PPS_TIME_MAX   32'sh0000_4E20
`define PPS_TIMES_MAX  32'sh0000_2710
`define PPS_COUNT_MAX  32'sh7FFF_FFFF
`define PPS_ZERO       32'h0000_0000
`define PPS_ONE        32'h0000_0001
`define PPS_PC0        6'h00
`define PPS_PC1        6'h01
`endif

// ### pps_pkg.sv
// Types shared by the positioning program sequencer
package pps_pkg;
    typedef enum logic [4:0] {
        PPS_OP_STOP     = 5'h00,
        PPS_OP_SPEED    = 5'h01,
        PPS_OP_ACC      = 5'h02,
        PPS_OP_DEC      = 5'h03,
        PPS_OP_ACCDEC   = 5'h04,
        PPS_OP_SCURVE   = 5'h05,
        PPS_OP_MOVABS   = 5'h06,
        PPS_OP_MOVINC   = 5'h07,
        PPS_OP_MOVABSC  = 5'h08,
        PPS_OP_MOVINCC  = 5'h09,
        PPS_OP_DWELL    = 5'h0A,
        PPS_OP_TIMES    = 5'h0B,
        PPS_OP_COUNT    = 5'h0C,
        PPS_OP_LOOP     = 5'h0D,
        PPS_OP_NEXT     = 5'h0E,
        PPS_OP_LATCH    = 5'h0F,
        PPS_OP_HOME     = 5'h10
    } pps_op_e;
    typedef enum logic [2:0] {
        PPS_S_IDLE   = 3'b000,
        PPS_S_FETCH  = 3'b001,
        PPS_S_EXEC   = 3'b010,
        PPS_S_MOTION = 3'b011,
        PPS_S_COUNT  = 3'b100,
        PPS_S_LATCH  = 3'b101,
        PPS_S_HOME   = 3'b110
    } pps_state_e;
    typedef logic [31:0] pps_word_t;
endpackage

// ### pps_word_regs.sv
// General purpose word registers with save stream for the retained group
`timescale 1ns/1ns
`default_nettype none
`include "pps_cfg.svh"
module pps_word_regs
    import pps_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    // Host write, blocked while a program runs
    input  wire logic                 busy_i,
    input  wire logic                 wr_en_i,
    input  wire logic [2:0]           wr_idx_i,
    input  wire pps_word_t            wr_data_i,
    // Indirect operand read
    input  wire logic [2:0]           rd_idx_i,
    output pps_word_t                 rd_data_o,
    // Save of the retained group
    input  wire logic                 save_i,
    output logic                      nv_wr_o,
    output logic [1:0]                nv_idx_o,
    output pps_word_t                 nv_data_o
);
    pps_word_t  regs_r   [`PPS_NREG];
    pps_word_t  regs_nxt [`PPS_NREG];
    logic       sav_r,   sav_nxt;
    logic [1:0] sidx_r,  sidx_nxt;
    logic       nvw_r,   nvw_nxt;
    logic [1:0] nvi_r,   nvi_nxt;
    pps_word_t  nvd_r,   nvd_nxt;

    assign rd_data_o = regs_r[rd_idx_i];
    assign nv_wr_o   = nvw_r;
    // Index registered with its word so both name the same entry
    assign nv_idx_o  = nvi_r;
    assign nv_data_o = nvd_r;

    // Per-entry next value; host writes ignored while running
    genvar g;
    for (g = 0; g < `PPS_NREG; g++) begin : g_reg
        always_comb begin
            regs_nxt[g] = regs_r[g];
            if (wr_en_i && !busy_i && wr_idx_i == 3'(g)) begin
                regs_nxt[g] = wr_data_i;
            end
        end
        // Cleared at power-up only, so contents die with power
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                regs_r[g] <= `PPS_ZERO;
            end else if (ce_i) begin
                regs_r[g] <= regs_nxt[g];
            end
        end
    end

    // Stream the four retained words out one per cycle
    always_comb begin
        sav_nxt  = sav_r;
        sidx_nxt = sidx_r;
        nvw_nxt  = 1'b0;
        nvd_nxt  = nvd_r;
        nvi_nxt  = nvi_r;
        if (sav_r) begin
            nvw_nxt  = 1'b1;
            nvd_nxt  = regs_r[{1'b0, sidx_r}];
            nvi_nxt  = sidx_r;
            sidx_nxt = sidx_r + 2'd1;
            sav_nxt  = (sidx_r != 2'(`PPS_NRET - 1));
        end else if (save_i) begin
            sav_nxt  = 1'b1;
            sidx_nxt = 2'd0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sav_r  <= 1'b0;
            sidx_r <= 2'd0;
            nvw_r  <= 1'b0;
            nvd_r  <= `PPS_ZERO;
            nvi_r  <= 2'd0;
        end else if (ce_i) begin
            sav_r  <= sav_nxt;
            sidx_r <= sidx_nxt;
            nvw_r  <= nvw_nxt;
            nvd_r  <= nvd_nxt;
            nvi_r  <= nvi_nxt;
        end
    end
endmodule
`default_nettype wire

// ### pps_sequencer.sv
// Positioning program sequencer: step engine, loops, latch, pulse count
`timescale 1ns/1ns
`default_nettype none
`include "pps_cfg.svh"
// How it works
// - Pulse-count step waits until accumulated count exceeds operand
// - Pulse-count step with zero operand clears the count instead
// - Loop body repeats operand times; zero means endless
// - Repeat step at address zero sets program runs; zero endless
// - Armed latch captures position on latch input rising edge
// - Latch step holds until the latch input has switched on
// - Captured position kept until power is removed
// - Latch disarms on edge, end, mode change, stop, alarm, servo-off
// - Temporary stop alone keeps the latch armed
// - Captured position is readable by the host
// - Motion, dwell and repeat steps may take a word register operand
// - Word registers clear at power-off; first group can be saved
// - Register operand must meet the consuming step's range
// - Home step starts home return and waits for completion
// - Failed home raises warning, continues, and blocks later travel
module pps_sequencer
    import pps_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 sys_clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 ce_i,
    // Program load and control
    input  wire logic                 prog_we_i,
    input  wire logic [`PPS_AW-1:0]   prog_addr_i,
    input  wire pps_word_t            prog_data_i,
    input  wire logic                 start_i,
    input  wire logic                 pause_i,
    input  wire logic                 mode_change_i,
    input  wire logic                 forced_stop_i,
    input  wire logic                 alarm_i,
    input  wire logic                 servo_off_i,
    // Word register access
    input  wire logic                 reg_we_i,
    input  wire logic [2:0]           reg_idx_i,
    input  wire pps_word_t            reg_data_i,
    input  wire logic                 reg_save_i,
    output logic                      nv_wr_o,
    output logic [1:0]                nv_idx_o,
    output pps_word_t                 nv_data_o,
    // Field inputs
    input  wire logic                 pulse_gen_i,
    input  wire logic                 latch_trigger_input_i,
    input  wire pps_word_t            position_i,
    // Motion engine handshake
    output logic                      motion_valid_o,
    output pps_op_e                   motion_op_o,
    output pps_word_t                 motion_value_o,
    input  wire logic                 motion_done_i,
    output logic                      home_start_o,
    input  wire logic                 home_done_i,
    input  wire logic                 home_ok_i,
    // Status
    output logic                      busy_o,
    output logic [`PPS_AW-1:0]        step_pc_o,
    output pps_word_t                 pulse_count_o,
    output pps_word_t                 latch_pos_o,
    output logic                      latch_armed_o,
    output logic                      home_incomplete_warning_o,
    output logic                      travel_inhibit_o,
    output logic                      range_err_o
);
    pps_word_t prog_mem [`PPS_DEPTH];
    logic rs1_r, rst_n;
    pps_state_e st_r, st_nxt;
    logic [`PPS_AW-1:0] pc_r, pc_nxt, lp_pc_r, lp_pc_nxt;
    pps_word_t ins_r, ins_nxt, opnd_r, opnd_nxt, cnt_r, cnt_nxt;
    pps_word_t lp_left_r, lp_left_nxt, runs_r, runs_nxt;
    pps_word_t position_latch_step_r, position_latch_step_nxt, mval_r, mval_nxt, rd_data;
    logic lp_inf_r, lp_inf_nxt, run_inf_r, run_inf_nxt;
    logic busy_r, busy_nxt, mv_r, mv_nxt, hs_r, hs_nxt;
    logic warn_r, warn_nxt, inh_r, inh_nxt, rerr_r, rerr_nxt;
    logic arm_r, arm_nxt, hit_r, hit_nxt, lat_d_r, pls_d_r;
    pps_op_e op, mop_r, mop_nxt;
    pps_word_t val;
    logic abort, lat_rise, pls_rise, clr_cnt, arm_go, ok;

    // Two-flop reset release
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // Program store, loaded only while idle
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && prog_we_i && !busy_r) begin
            prog_mem[prog_addr_i] <= prog_data_i;
        end
    end

    pps_word_regs u_regs (
        .clk_i     (sys_clk_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .busy_i    (busy_r),
        .wr_en_i   (reg_we_i),
        .wr_idx_i  (reg_idx_i),
        .wr_data_i (reg_data_i),
        .rd_idx_i  (ins_r[`PPS_RIDX_HI:0]),
        .rd_data_o (rd_data),
        .save_i    (reg_save_i),
        .nv_wr_o   (nv_wr_o),
        .nv_idx_o  (nv_idx_o),
        .nv_data_o (nv_data_o)
    );

    // Decode; indirect operand taken from a word register
    always_comb begin
        op  = pps_op_e'(ins_r[`PPS_OPC_HI:`PPS_OPC_LO]);
        val = ins_r[`PPS_IND_BIT] ? rd_data
            : {{6{ins_r[`PPS_IMM_HI]}}, ins_r[`PPS_IMM_HI:0]};
        case (op)
            PPS_OP_MOVABS, PPS_OP_MOVINC, PPS_OP_MOVABSC, PPS_OP_MOVINCC:
                ok = $signed(val) <= `PPS_TRAVEL_MAX
                  && $signed(val) >= -`PPS_TRAVEL_MAX;
            PPS_OP_SPEED:
                ok = $signed(val) >= 0 && $signed(val) <= `PPS_SPEED_MAX;
            PPS_OP_ACC, PPS_OP_DEC, PPS_OP_ACCDEC, PPS_OP_SCURVE,
            PPS_OP_DWELL:
                ok = $signed(val) >= 0 && $signed(val) <= `PPS_TIME_MAX;
            PPS_OP_TIMES, PPS_OP_LOOP:
                ok = $signed(val) >= 0 && $signed(val) <= `PPS_TIMES_MAX;
            PPS_OP_COUNT:
                ok = $signed(val) >= 0 && $signed(val) <= `PPS_COUNT_MAX;
            default:
                ok = 1'b1;
        endcase
        abort    = mode_change_i | forced_stop_i | alarm_i | servo_off_i;
        lat_rise = latch_trigger_input_i & ~lat_d_r;
        pls_rise = pulse_gen_i & ~pls_d_r;
    end

    // Step engine next state
    always_comb begin
        st_nxt = st_r; pc_nxt = pc_r; ins_nxt = ins_r; opnd_nxt = opnd_r;
        lp_pc_nxt = lp_pc_r; lp_left_nxt = lp_left_r; lp_inf_nxt = lp_inf_r;
        runs_nxt = runs_r; run_inf_nxt = run_inf_r; busy_nxt = busy_r;
        mv_nxt = mv_r; mop_nxt = mop_r; mval_nxt = mval_r; hs_nxt = 1'b0;
        warn_nxt = warn_r; inh_nxt = inh_r; rerr_nxt = rerr_r;
        clr_cnt = 1'b0; arm_go = 1'b0;
        if (busy_r && abort) begin
            st_nxt = PPS_S_IDLE; busy_nxt = 1'b0; mv_nxt = 1'b0;
        end else if (!pause_i) begin
            case (st_r)
                PPS_S_IDLE: if (start_i) begin
                    st_nxt = PPS_S_FETCH; pc_nxt = `PPS_PC0;
                    busy_nxt = 1'b1; runs_nxt = `PPS_ONE;
                    run_inf_nxt = 1'b0; lp_inf_nxt = 1'b0;
                    warn_nxt = 1'b0; inh_nxt = 1'b0; rerr_nxt = 1'b0;
                end
                PPS_S_FETCH: begin
                    ins_nxt = prog_mem[pc_r]; st_nxt = PPS_S_EXEC;
                end
                PPS_S_EXEC: begin
                    opnd_nxt = val; st_nxt = PPS_S_FETCH;
                    pc_nxt = pc_r + `PPS_PC1;
                    if (!ok) begin
                        rerr_nxt = 1'b1; st_nxt = PPS_S_IDLE; busy_nxt = 1'b0;
                    end else case (op)
                        PPS_OP_STOP:
                            if (run_inf_r || runs_r > `PPS_ONE) begin
                                runs_nxt = runs_r - `PPS_ONE;
                                pc_nxt = `PPS_PC1;
                            end else begin
                                st_nxt = PPS_S_IDLE; busy_nxt = 1'b0;
                            end
                        PPS_OP_TIMES: if (pc_r == `PPS_PC0) begin
                            runs_nxt = val; run_inf_nxt = (val == `PPS_ZERO);
                        end
                        PPS_OP_COUNT:
                            if (val == `PPS_ZERO) clr_cnt = 1'b1;
                            else begin
                                st_nxt = PPS_S_COUNT; pc_nxt = pc_r;
                            end
                        PPS_OP_LOOP: begin
                            lp_pc_nxt = pc_r + `PPS_PC1; lp_left_nxt = val;
                            lp_inf_nxt = (val == `PPS_ZERO);
                        end
                        PPS_OP_NEXT:
                            if (lp_inf_r || lp_left_r > `PPS_ONE) begin
                                lp_left_nxt = lp_left_r - `PPS_ONE;
                                pc_nxt = lp_pc_r;
                            end
                        PPS_OP_LATCH: begin
                            arm_go = 1'b1; st_nxt = PPS_S_LATCH;
                            pc_nxt = pc_r;
                        end
                        PPS_OP_HOME: begin
                            hs_nxt = 1'b1; st_nxt = PPS_S_HOME; pc_nxt = pc_r;
                        end
                        PPS_OP_MOVABS, PPS_OP_MOVINC, PPS_OP_MOVABSC,
                        PPS_OP_MOVINCC:
                            if (!inh_r) begin
                                mv_nxt = 1'b1; mop_nxt = op; mval_nxt = val;
                                st_nxt = PPS_S_MOTION; pc_nxt = pc_r;
                            end
                        default: begin
                            mv_nxt = 1'b1; mop_nxt = op; mval_nxt = val;
                            st_nxt = PPS_S_MOTION; pc_nxt = pc_r;
                        end
                    endcase
                end
                PPS_S_MOTION: if (motion_done_i) begin
                    mv_nxt = 1'b0; st_nxt = PPS_S_FETCH;
                    pc_nxt = pc_r + `PPS_PC1;
                end
                PPS_S_COUNT: if (cnt_r > opnd_r) begin
                    st_nxt = PPS_S_FETCH; pc_nxt = pc_r + `PPS_PC1;
                end
                PPS_S_LATCH: if (hit_r) begin
                    st_nxt = PPS_S_FETCH; pc_nxt = pc_r + `PPS_PC1;
                end
                PPS_S_HOME: if (home_done_i) begin
                    if (!home_ok_i) begin
                        warn_nxt = 1'b1; inh_nxt = 1'b1;
                    end
                    st_nxt = PPS_S_FETCH; pc_nxt = pc_r + `PPS_PC1;
                end
                default: begin
                    st_nxt = PPS_S_IDLE; busy_nxt = 1'b0;
                end
            endcase
        end
    end

    // Latch and pulse counter next state
    always_comb begin
        arm_nxt = arm_r; hit_nxt = hit_r; position_latch_step_nxt = position_latch_step_r;
        cnt_nxt = clr_cnt ? `PPS_ZERO : cnt_r;
        if (pls_rise) cnt_nxt = cnt_nxt + `PPS_ONE;
        if (arm_go) begin
            arm_nxt = 1'b1; hit_nxt = 1'b0;
        end else if (arm_r && lat_rise) begin
            position_latch_step_nxt = position_i;
            arm_nxt = 1'b0; hit_nxt = 1'b1;
        end
        if (abort || (busy_r && !busy_nxt)) arm_nxt = 1'b0;
    end

    // State registers; pause is not a disarm event
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= PPS_S_IDLE; pc_r <= `PPS_PC0; ins_r <= `PPS_ZERO;
            opnd_r <= `PPS_ZERO; lp_pc_r <= `PPS_PC0;
            lp_left_r <= `PPS_ZERO; lp_inf_r <= 1'b0;
            runs_r <= `PPS_ZERO; run_inf_r <= 1'b0; busy_r <= 1'b0;
            mv_r <= 1'b0; mop_r <= PPS_OP_STOP; mval_r <= `PPS_ZERO;
            hs_r <= 1'b0; warn_r <= 1'b0; inh_r <= 1'b0; rerr_r <= 1'b0;
            arm_r <= 1'b0; hit_r <= 1'b0; position_latch_step_r <= `PPS_ZERO;
            cnt_r <= `PPS_ZERO; lat_d_r <= 1'b0; pls_d_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt; pc_r <= pc_nxt; ins_r <= ins_nxt;
            opnd_r <= opnd_nxt; lp_pc_r <= lp_pc_nxt;
            lp_left_r <= lp_left_nxt; lp_inf_r <= lp_inf_nxt;
            runs_r <= runs_nxt; run_inf_r <= run_inf_nxt;
            busy_r <= busy_nxt; mv_r <= mv_nxt; mop_r <= mop_nxt;
            mval_r <= mval_nxt; hs_r <= hs_nxt; warn_r <= warn_nxt;
            inh_r <= inh_nxt; rerr_r <= rerr_nxt; arm_r <= arm_nxt;
            hit_r <= hit_nxt; position_latch_step_r <= position_latch_step_nxt; cnt_r <= cnt_nxt;
            lat_d_r <= latch_trigger_input_i; pls_d_r <= pulse_gen_i;
        end
    end

    // Status straight from flops
    assign motion_valid_o = mv_r;
    assign motion_op_o = mop_r;
    assign motion_value_o = mval_r;
    assign home_start_o = hs_r;
    assign busy_o = busy_r;
    assign step_pc_o = pc_r;
    assign pulse_count_o = cnt_r;
    assign latch_pos_o = position_latch_step_r;
    assign latch_armed_o = arm_r;
    assign home_incomplete_warning_o = warn_r;
    assign travel_inhibit_o = inh_r;
    assign range_err_o = rerr_r;

    // Checks
    sequence s_home_fail;
        st_r == PPS_S_HOME && home_done_i && !home_ok_i && ce_i
            && !pause_i && !abort;
    endsequence
    sequence s_warned;
        warn_r && inh_r && st_r == PPS_S_FETCH;
    endsequence
    property p_count_hold;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (st_r == PPS_S_COUNT && cnt_r <= opnd_r && !abort)
            |=> st_r == PPS_S_COUNT;
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("count left early");
    property p_count_clear;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (clr_cnt && ce_i && !pls_rise) |=> cnt_r == `PPS_ZERO;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("count not cleared");
    property p_loop_back;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (st_r == PPS_S_EXEC && op == PPS_OP_NEXT && ok && ce_i && !pause_i
            && !abort && lp_left_r > `PPS_ONE) |=> pc_r == $past(lp_pc_r);
    endproperty
    a_loop_back: assert property (p_loop_back)
        else $error("loop not taken");
    property p_latch_hold;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (st_r == PPS_S_LATCH && !hit_r && !abort) |=> st_r == PPS_S_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch step passed");
    property p_capture;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (arm_r && lat_rise && ce_i)
            |=> position_latch_step_r == $past(position_i) && !arm_r && hit_r;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture failed");
    property p_kept;
        @(posedge sys_clk_i) disable iff (!rst_n)
        !(arm_r && lat_rise && ce_i) |=> $stable(position_latch_step_r);
    endproperty
    a_kept: assert property (p_kept)
        else $error("latched value moved");
    property p_abort_disarm;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (abort && ce_i) |=> !arm_r;
    endproperty
    a_abort_disarm: assert property (p_abort_disarm)
        else $error("still armed");
    property p_pause_keep;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (arm_r && pause_i && !abort && !lat_rise) |=> arm_r;
    endproperty
    a_pause_keep: assert property (p_pause_keep)
        else $error("pause disarmed");
    property p_home_fail;
        @(posedge sys_clk_i) disable iff (!rst_n)
        s_home_fail |=> s_warned;
    endproperty
    a_home_fail: assert property (p_home_fail)
        else $error("home fail lost");
    property p_pulse_inc;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (pls_rise && ce_i && !clr_cnt) |=> cnt_r == $past(cnt_r) + `PPS_ONE;
    endproperty
    a_pulse_inc: assert property (p_pulse_inc)
        else $error("pulse not counted");
endmodule
`default_nettype wire

// ### pps_motion_model.sv
// Motion and home engine model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module pps_motion_model #(parameter int DLY = 3) (
    // Requests from the sequencer
    input  wire logic sys_clk_i,
    input  wire logic motion_valid_i,
    input  wire logic home_start_i,
    input  wire logic ok_cfg_i,
    // Answers
    output logic      motion_done_o,
    output logic      home_done_o,
    output logic      home_ok_o
);
    int mc, hc;
    // Travel answered after DLY cycles, done stands one cycle
    always_ff @(posedge sys_clk_i) begin
        mc <= (motion_valid_i && !motion_done_o) ? mc + 1 : 0;
        hc <= home_start_i ? DLY : ((hc > 0) ? hc - 1 : 0);
    end
    assign motion_done_o = motion_valid_i && (mc == DLY);
    assign home_done_o   = (hc == 1);
    // Status is meaningless outside done, so show its inverse
    assign home_ok_o     = home_done_o ? ok_cfg_i : !ok_cfg_i;
endmodule
`default_nettype wire

// ### test_pps_sequencer.sv
// Self-checking bench for the positioning program sequencer
`timescale 1ns/1ns
`default_nettype none
module test_pps_sequencer;
    import pps_pkg::*;
    logic sys_clk_i, nrst_i, we, st, pz, mch, fst, alm, sof, rwe, pg, trg;
    logic mv, md, hs, hd, hok, ok, busy, armed, warn, inh, rerr, mq, sv, nvw;
    logic [5:0] addr, pc;
    logic [2:0] ridx;
    logic [1:0] nvi;
    pps_word_t  pd, rd, pos, mval, pcnt, position_latch_step, mvl, nvd;
    pps_op_e    mop;
    int failures, check_count, mc;
    pps_sequencer pps_sequencer_i (.sys_clk_i, .nrst_i, .ce_i(1'b1),
        .prog_we_i(we), .prog_addr_i(addr), .prog_data_i(pd), .start_i(st),
        .pause_i(pz), .mode_change_i(mch), .forced_stop_i(fst),
        .alarm_i(alm), .servo_off_i(sof), .reg_we_i(rwe), .reg_idx_i(ridx),
        .reg_data_i(rd), .reg_save_i(sv), .nv_wr_o(nvw), .nv_idx_o(nvi),
        .nv_data_o(nvd), .pulse_gen_i(pg), .latch_trigger_input_i(trg),
        .position_i(pos), .motion_valid_o(mv), .motion_op_o(mop),
        .motion_value_o(mval), .motion_done_i(md), .home_start_o(hs),
        .home_done_i(hd), .home_ok_i(hok), .busy_o(busy), .step_pc_o(pc),
        .pulse_count_o(pcnt), .latch_pos_o(position_latch_step), .latch_armed_o(armed),
        .home_incomplete_warning_o(warn), .travel_inhibit_o(inh),
        .range_err_o(rerr));
    pps_motion_model pps_motion_model_i (.sys_clk_i, .motion_valid_i(mv),
        .home_start_i(hs), .ok_cfg_i(ok), .motion_done_o(md),
        .home_done_o(hd), .home_ok_o(hok));
    // Clock
    initial begin
        sys_clk_i = 0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // Count travel requests and keep the last operand, sampled when settled
    always @(negedge sys_clk_i) begin
        mq <= mv;
        if (mv && !mq) begin
            mc++;
            mvl = mval;
        end
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #5;
    endtask
    task automatic chk(string nm, pps_word_t seen, pps_word_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wp(logic [5:0] a, pps_op_e op, logic ind, int imm);
        we = 1; addr = a; pd = {op, ind, imm[25:0]};
        tick();
        we = 0;
        tick();
    endtask
    // Start a run; optionally wait for the end under a bound
    task automatic run(bit wait_end = 1);
        int n;
        mc = 0; st = 1;
        tick();
        st = 0;
        for (n = 0; wait_end && busy !== 1'b0 && n < 3000; n++) tick();
        if (n >= 3000) chk("run end", 0, 1);
        tick();
    endtask
    task automatic pulse();
        pg = 1; tick(); pg = 0; tick();
    endtask
    task automatic t_count();
        wp(0, PPS_OP_COUNT, 0, 3); wp(1, PPS_OP_STOP, 0, 0);
        run(0); tick(4); repeat (3) pulse();
        chk("count wait", busy, 1);
        chk("count step", pc, 0);
        pulse(); tick(5);
        chk("count done", busy, 0);
        chk("count", pcnt, 4);
        wp(0, PPS_OP_COUNT, 0, 0); run();
        chk("count clear", pcnt, 0);
    endtask
    task automatic t_latch();
        wp(0, PPS_OP_LATCH, 0, 0); wp(1, PPS_OP_STOP, 0, 0);
        pos = 32'h0000_1234; run(0); tick(4);
        chk("hold", busy, 1);
        pz = 1; tick(3);
        chk("armed in pause", armed, 1);
        pz = 0; trg = 1; tick();
        chk("disarm on edge", armed, 0);
        pos = 32'h0000_5555; tick(6);
        trg = 0;
        chk("captured", position_latch_step, 32'h0000_1234);
        chk("latch step done", busy, 0);
        run(0); tick(4); fst = 1; tick(2); fst = 0;
        chk("disarm on stop", {busy, armed}, 0);
        chk("kept", position_latch_step, 32'h0000_1234);
    endtask
    task automatic t_loops();
        // Single loop level only, as programs must keep it
        wp(0, PPS_OP_TIMES, 0, 2); wp(1, PPS_OP_LOOP, 0, 3);
        wp(2, PPS_OP_SPEED, 0, 5); wp(3, PPS_OP_NEXT, 0, 0);
        wp(4, PPS_OP_STOP, 0, 0); run();
        chk("loops x runs", mc, 6);
        wp(0, PPS_OP_LOOP, 0, 2); wp(1, PPS_OP_SPEED, 0, 5);
        wp(2, PPS_OP_NEXT, 0, 0); wp(3, PPS_OP_STOP, 0, 0); run();
        chk("single run", mc, 2);
        wp(0, PPS_OP_LOOP, 0, 0); run(0); tick(200);
        chk("endless", {busy, mc > 10}, 3);
        mch = 1; tick(2); mch = 0;
        chk("abort", busy, 0);
    endtask
    task automatic t_regs();
        // Registers only written while idle
        rwe = 1; ridx = 5; rd = 32'h0000_0064; tick();
        ridx = 1; rd = 32'h0000_2711; tick(); rwe = 0;
        sv = 1; tick(); sv = 0; tick(2);
        chk("save index", {nvw, nvi}, 5);
        chk("save word", nvd, 32'h0000_2711);
        wp(0, PPS_OP_SPEED, 1, 5); wp(1, PPS_OP_STOP, 0, 0); run();
        chk("indirect", mvl, 32'h0000_0064);
        chk("indirect op", mop, PPS_OP_SPEED);
        wp(0, PPS_OP_SPEED, 1, 1); run();
        chk("range", rerr, 1);
    endtask
    task automatic t_home();
        wp(0, PPS_OP_HOME, 0, 0); wp(1, PPS_OP_MOVABS, 0, 10);
        wp(2, PPS_OP_STOP, 0, 0); ok = 0; run();
        chk("warn", {warn, inh}, 3);
        chk("travel blocked", mc, 0);
        ok = 1; run();
        chk("home ok", warn, 0);
        chk("travel after home", mc, 1);
    endtask
    // Alarm and servo-off each drop an armed latch
    task automatic t_abort();
        wp(0, PPS_OP_LATCH, 0, 0); run(0); tick(2);
        chk("armed", armed, 1);
        alm = 1; tick(2); alm = 0;
        chk("disarm on alarm", {busy, armed}, 0);
        run(0); tick(2); sof = 1; tick(2); sof = 0;
        chk("disarm on servo-off", {busy, armed}, 0);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #2_000_000;
        failures++;
        summarize();
    end
    initial begin
        {nrst_i, we, st, pz, mch, fst, alm, sof, rwe, pg, trg, ok, sv} = 0;
        addr = 0; ridx = 0; pd = 0; rd = 0; pos = 0; mc = 0;
        tick(3); nrst_i = 1; tick(3);
        t_count(); t_latch(); t_loops(); t_regs(); t_home();
        t_abort();
        summarize();
    end
endmodule
`default_nettype wire
